//--- brw_map.vh
// Constants for the board reset watchdog
`ifndef BRW_MAP_VH
`define BRW_MAP_VH
`define BRW_CLK_HZ        24'd10000000
`define BRW_SEC_CNT_W     24
`define BRW_SEC_LAST      24'd9999999
`define BRW_TMO_W         8
`define BRW_TMO_RST       8'h0a
`define BRW_EN_RST        1'b1
`endif

//--- brw_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module brw_sync (
  // Clock and reset
  input  wire core_clk,
  input  wire rst,
  // Data
  input  wire din,
  output reg  dout_ff
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  wire nxt_dout;

  // Output moves only when stages two and three agree
  assign nxt_dout = (s2_ff == s3_ff) ? s2_ff : dout_ff;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
      dout_ff <= 1'b0;
    end else begin
      s1_ff   <= din;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      dout_ff <= nxt_dout;
    end
  end
endmodule // brw_sync

//--- brw_watchdog.v
// Board reset watchdog with seconds time base
`timescale 1ns/10ps
`include "brw_map.vh"
// Operation
// - Watchdog leaves reset enabled and counting, no software arming.
// - Disable request ignored unless debugger-connected indication is active.
// - Timeout without kick requests a whole-board reset.
// - Any kick write counts, data value ignored.
// - Timeout value 0 to 255 gives 1 to 256 seconds; software kicks faster than that.
// - Enable value 1 enables, 0 disables; default 1.
// - Expiry resets board only when error manager enabled reset.
module brw_watchdog #(
  // Last prescaler count of one second; benches may shorten it
  parameter [`BRW_SEC_CNT_W-1:0] SEC_LAST = `BRW_SEC_LAST
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // Software controls, same clock domain
  input  wire       kick_wr,
  input  wire [7:0] kick_data,
  input  wire       enable_wr,
  input  wire       enable_val,
  input  wire       timeout_wr,
  input  wire [7:0] timeout_val,
  // Debugger presence pin, asynchronous
  input  wire       dbg_connected,
  // Error manager reset enable, same clock domain
  input  wire       errman_rst_en,
  // Status and reset request
  output reg        wdt_enabled_ff,
  output reg  [7:0] timeout_ff,
  output reg  [7:0] secs_left_ff,
  output reg        expired_ff,
  output reg        board_rst_req_ff
);
  reg  [`BRW_SEC_CNT_W-1:0] tick_cnt_ff;
  reg  [`BRW_SEC_CNT_W-1:0] nxt_tick_cnt;
  reg  [7:0]                nxt_secs_left;
  reg                       nxt_enabled;
  reg                       nxt_expired;
  reg                       nxt_rst_req;
  wire                      dbg_sync;
  wire                      restart;
  wire                      sec_tick;

  brw_sync u_dbg_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .din      (dbg_connected),
    .dout_ff  (dbg_sync)
  );

  // Data ignored: writing at all is the kick
  assign restart  = kick_wr | timeout_wr;
  assign sec_tick = (tick_cnt_ff == SEC_LAST);

  always @* begin
    nxt_enabled = wdt_enabled_ff;
    if (enable_wr) begin
      if (enable_val)
        nxt_enabled = 1'b1;
      else if (dbg_sync)
        nxt_enabled = 1'b0;
    end
  end

  // Timeout of zero expires at the first second tick
  always @* begin
    nxt_tick_cnt  = tick_cnt_ff;
    nxt_secs_left = secs_left_ff;
    nxt_expired   = expired_ff;
    if (restart) begin
      nxt_tick_cnt  = {`BRW_SEC_CNT_W{1'b0}};
      nxt_secs_left = timeout_wr ? timeout_val : timeout_ff;
      nxt_expired   = 1'b0;
    end else if (wdt_enabled_ff && !expired_ff) begin
      nxt_tick_cnt = sec_tick ? {`BRW_SEC_CNT_W{1'b0}} : tick_cnt_ff + 1'b1;
      if (sec_tick) begin
        if (secs_left_ff == 8'h00)
          nxt_expired = 1'b1;
        else
          nxt_secs_left = secs_left_ff - 8'h01;
      end
    end
  end

  // Request held until a kick; gated by error manager enable
  always @* begin
    nxt_rst_req = nxt_expired & errman_rst_en;
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wdt_enabled_ff   <= `BRW_EN_RST;
      timeout_ff       <= `BRW_TMO_RST;
      secs_left_ff     <= `BRW_TMO_RST;
      tick_cnt_ff      <= {`BRW_SEC_CNT_W{1'b0}};
      expired_ff       <= 1'b0;
      board_rst_req_ff <= 1'b0;
    end else begin
      wdt_enabled_ff   <= nxt_enabled;
      if (timeout_wr)
        timeout_ff     <= timeout_val;
      secs_left_ff     <= nxt_secs_left;
      tick_cnt_ff      <= nxt_tick_cnt;
      expired_ff       <= nxt_expired;
      board_rst_req_ff <= nxt_rst_req;
    end
  end
endmodule // brw_watchdog

//--- brw_watchdog_checker.sv
// Assertion checker for the board reset watchdog
`timescale 1ns/10ps
module brw_chk (input core_clk, rst, kick_wr, enable_wr, enable_val,
  timeout_wr, dbg_connected, errman_rst_en, wdt_enabled_ff, expired_ff,
  board_rst_req_ff, input [7:0] timeout_val, timeout_ff, secs_left_ff);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_boot_on: assert property ($past(rst) |-> wdt_enabled_ff)
    else $error("not enabled at boot");
  // Eight quiet cycles cover the debugger pin filter delay
  a_dis_refused: assert property (!dbg_connected[*8] ##1 enable_wr
    |=> wdt_enabled_ff) else $error("disabled without debugger");
  a_en_set: assert property (enable_wr && enable_val |=> wdt_enabled_ff)
    else $error("enable ignored");
  a_expire_zero: assert property ($rose(expired_ff) |->
    $past(secs_left_ff) == 8'h00) else $error("early expiry");
  a_req_gate: assert property (board_rst_req_ff |->
    expired_ff && $past(errman_rst_en)) else $error("reset not gated");
  a_kick_restart: assert property (kick_wr && !timeout_wr |=>
    secs_left_ff == $past(timeout_ff) && !expired_ff) else $error("kick");
  a_tmo_load: assert property (timeout_wr |=> timeout_ff ==
    $past(timeout_val) && secs_left_ff == timeout_ff) else $error("load");
  a_secs_bound: assert property (secs_left_ff <= timeout_ff)
    else $error("count above timeout");
endmodule // brw_chk
bind brw_watchdog brw_chk u_chk (.*);

//--- brw_watchdog_test.sv
// Testbench for the board reset watchdog
`timescale 1ns/10ps
module brw_watchdog_test;
  logic       core_clk = 0, rst = 1, kick_wr = 0, enable_wr = 0;
  logic       enable_val = 0, timeout_wr = 0, dbg_connected = 0;
  logic       errman_rst_en = 1, wdt_enabled_ff, expired_ff, board_rst_req_ff;
  logic [7:0] kick_data = 8'h5a, timeout_val = 8'h00, timeout_ff, secs_left_ff;
  int         error_cnt = 0, n_tests = 0;
  // Short second keeps expiry inside the run budget
  brw_watchdog #(.SEC_LAST(24'd99)) uut (.*);
  initial forever #50 core_clk = ~core_clk;
  task chk(input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One-cycle write pulse, launched off the falling edge
  task wr(input logic k, e, v, t, input logic [7:0] d);
    @(negedge core_clk);
    {kick_wr, enable_wr, enable_val, timeout_wr} = {k, e, v, t};
    timeout_val = d;
    @(negedge core_clk);
    {kick_wr, enable_wr, timeout_wr} = 3'h0;
  endtask
  task t_enable;
    chk(wdt_enabled_ff, 8'h01);
    wr(0, 1, 0, 0, 8'h00);
    chk(wdt_enabled_ff, 8'h01);
    dbg_connected = 1;
    repeat (8) @(negedge core_clk);
    wr(0, 1, 0, 0, 8'h00);
    chk(wdt_enabled_ff, 8'h00);
    wr(0, 1, 1, 0, 8'h00);
    chk(wdt_enabled_ff, 8'h01);
    dbg_connected = 0;
  endtask
  task t_timeout;
    chk(secs_left_ff, 8'h0a);
    wr(1, 0, 0, 1, 8'hff);
    chk(secs_left_ff, 8'hff);
    wr(0, 0, 0, 1, 8'h07);
    chk(timeout_ff, 8'h07);
    wr(1, 0, 0, 0, 8'h00);
    chk(secs_left_ff, 8'h07);
    chk(expired_ff | board_rst_req_ff, 8'h00);
  endtask
  task t_expire;
    int i;
    i = 0;
    errman_rst_en = 1;
    wr(0, 0, 0, 1, 8'h00);
    while (!expired_ff && i < 300) begin
      @(negedge core_clk);
      i++;
    end
    chk(i[7:0], 8'd100);
    chk(board_rst_req_ff, 8'h01);
    errman_rst_en = 0;
    @(negedge core_clk);
    chk(board_rst_req_ff, 8'h00);
    chk(expired_ff, 8'h01);
    wr(1, 0, 0, 0, 8'h00);
    chk(expired_ff, 8'h00);
    chk(secs_left_ff, 8'h00);
    errman_rst_en = 1;
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    rst = 0;
    t_enable;
    t_timeout;
    t_expire;
    test_done;
  end
endmodule // brw_watchdog_test
